// ===== rtl/grs_pkg.sv
// Package for the rate sensor register space access layer.
// Assumes a byte-wide register port driven by a serial front end on ref_clk.
package grs_pkg;
    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned NUM_REGS = 64;
    // ----------------------------------------------------------------
    // Address map
    // ----------------------------------------------------------------
    localparam logic [5:0] RO_LAST = 6'h0E;
    localparam logic [5:0] SOFT_RESET_ADDR = 6'h14;
    localparam logic [5:0] INT_CTRL_ADDR = 6'h21;
    localparam logic [5:0] FIFO_READ_ADDR = 6'h3F;
    localparam logic [7:0] SOFT_RESET_KEY = 8'hB6;
    localparam int unsigned INT_RESET_BIT = 7;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] FIFO_RESET = 8'h00;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } grs_req_t;
endpackage

// ===== rtl/grs_decode.sv
// Address classifier for the rate sensor register space.
// Assumes addresses are already confined to the 64-entry map.
`timescale 1ns/10ps
module grs_decode (
    input wire logic [5:0] addr, // Register address
    input wire logic [63:0] reserved_map, // One bit per fully reserved address
    output logic is_ro, // Address is read-only: the 0x00 to 0x0E range or the FIFO read address
    output logic is_resv, // Address is fully reserved
    output logic is_soft_rst // Address is the soft-reset trigger
);
    always_comb begin
        is_ro = (addr <= grs_pkg::RO_LAST) || (addr == grs_pkg::FIFO_READ_ADDR);
        is_resv = reserved_map[addr];
        is_soft_rst = (addr == grs_pkg::SOFT_RESET_ADDR);
    end
endmodule

// ===== rtl/grs_regs.sv
// Register bank of the rate sensor: byte registers, access filtering and triggers.
// Assumes a serial front end presents one-cycle read/write strobes on ref_clk.
//
// What this block does
// - Each register is eight bits wide and each access moves exactly one byte.
// - Addresses 0x00 to 0x3F, sixty-four in all, are decoded contiguously.
// - Writes never change reserved bit positions; they are stored as zero and always read zero.
// - Addresses 0x00 to 0x0E are read-only and writes to them are dropped silently.
// - Trigger bits, such as the interrupt reset bit at 0x21 and all of 0x14, are write-only and read zero.
`timescale 1ns/10ps
module grs_regs #(
    parameter logic [63:0] RESERVED_MAP = 64'h0000_0000_0000_0000, // Fully reserved addresses
    parameter logic [7:0] RESV_MASK_DEFAULT = 8'h00 // Reserved bits in every writable register
) (
    input wire logic ref_clk, // 100 MHz clock
    input wire logic nrst, // Synchronous reset, active low
    input wire grs_pkg::grs_req_t req, // Register request from the serial front end
    output logic [7:0] rdata, // Read data, registered
    output logic rvalid, // Read data valid, one cycle
    input wire logic [7:0] status_in [0:14], // Status bytes for the read-only range
    input wire logic [7:0] fifo_data_in, // Byte presented by the FIFO read port
    output logic fifo_pop, // Pulse: FIFO byte consumed
    output logic soft_reset_pulse, // Pulse: soft reset requested
    output logic int_reset_pulse, // Pulse: latched interrupts cleared
    output logic [7:0] ctrl_out [0:63] // Current contents of the writable registers
);
    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (grs_pkg::NUM_REGS != (1 << grs_pkg::ADDR_W)) begin : g_chk
        $error("register count does not match address width");
    end

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    logic is_ro;
    logic is_resv;
    logic is_soft_rst;

    grs_decode u_dec (
        .addr(req.addr),
        .reserved_map(RESERVED_MAP),
        .is_ro(is_ro),
        .is_resv(is_resv),
        .is_soft_rst(is_soft_rst)
    );

    // Trigger bits per address: these never store and read zero
    function automatic logic [7:0] trig_mask(input logic [5:0] a);
        logic [7:0] m;
        m = 8'h00;
        if (a == grs_pkg::SOFT_RESET_ADDR) begin
            m = 8'hFF;
        end else if (a == grs_pkg::INT_CTRL_ADDR) begin
            m = 8'h01 << grs_pkg::INT_RESET_BIT;
        end
        return m;
    endfunction

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [7:0] mem_q [0:63];
    logic [7:0] mem_d [0:63];
    logic [7:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic soft_q, soft_d;
    logic intr_q, intr_d;
    logic pop_q, pop_d;
    logic [7:0] keep;

    always_comb begin
        for (int i = 0; i < 64; i++) begin
            mem_d[i] = mem_q[i];
        end
        // Bits that hold state: not reserved, not triggers
        keep = ~(RESV_MASK_DEFAULT | trig_mask(req.addr));
        soft_d = 1'b0;
        intr_d = 1'b0;
        if (req.wr && !is_ro && !is_resv) begin
            mem_d[req.addr] = (mem_q[req.addr] & ~keep) | (req.wdata & keep);
            if (is_soft_rst && req.wdata == grs_pkg::SOFT_RESET_KEY) begin
                soft_d = 1'b1;
            end
            if (req.addr == grs_pkg::INT_CTRL_ADDR) begin
                intr_d = req.wdata[grs_pkg::INT_RESET_BIT];
            end
        end
        // Stored trigger and reserved bits stay zero, so reads are deterministic
        for (int i = 0; i < 64; i++) begin
            mem_d[i] = mem_d[i] & ~(RESV_MASK_DEFAULT | trig_mask(6'(i)));
        end
        rvalid_d = req.rd;
        pop_d = req.rd && (req.addr == grs_pkg::FIFO_READ_ADDR);
        rdata_d = rdata_q;
        if (req.rd) begin
            if (is_resv) begin
                rdata_d = 8'h00;
            end else if (req.addr <= grs_pkg::RO_LAST) begin
                rdata_d = status_in[4'(req.addr)];
            end else if (req.addr == grs_pkg::FIFO_READ_ADDR) begin
                rdata_d = fifo_data_in;
            end else begin
                rdata_d = mem_q[req.addr] & ~(RESV_MASK_DEFAULT | trig_mask(req.addr));
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst || soft_q) begin
            for (int i = 0; i < 64; i++) begin
                mem_q[i] <= grs_pkg::REG_RESET;
            end
            rdata_q <= grs_pkg::FIFO_RESET;
            rvalid_q <= 1'b0;
            intr_q <= 1'b0;
            pop_q <= 1'b0;
        end else begin
            mem_q <= mem_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            intr_q <= intr_d;
            pop_q <= pop_d;
        end
    end

    // Soft reset pulse is held apart so it can clear the bank one cycle later
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            soft_q <= 1'b0;
        end else begin
            soft_q <= soft_d;
        end
    end

    assign rdata = rdata_q;
    assign rvalid = rvalid_q;
    assign soft_reset_pulse = soft_q;
    assign int_reset_pulse = intr_q;
    assign fifo_pop = pop_q;
    assign ctrl_out = mem_q;
endmodule

// ===== tb/grs_regs_sva.sv
// Checker for the register bank ports.
// Assumes a bind onto grs_regs, one ref_clk domain.
`timescale 1ns/10ps
module grs_regs_sva #(
    parameter logic [7:0] RESV_MASK_DEFAULT = 8'h00 // Reserved bits
) (
    input wire logic ref_clk, // Clock
    input wire logic nrst, // Reset
    input wire grs_pkg::grs_req_t req, // Request
    input wire logic [7:0] rdata, // Read byte
    input wire logic rvalid, // Read valid
    input wire logic [7:0] status_in [0:14], // Status
    input wire logic [7:0] fifo_data_in, // FIFO byte
    input wire logic fifo_pop, // Pop
    input wire logic soft_reset_pulse, // Soft reset
    input wire logic int_reset_pulse, // Int reset
    input wire logic [7:0] ctrl_out [0:63] // Bank
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    logic [7:0] sel_q;
    logic rd_ok;
    logic wr_ok;
    assign rd_ok = req.rd && !soft_reset_pulse;
    assign wr_ok = req.wr && !soft_reset_pulse;
    // Index wraps above 0x0F; only looked at inside the read-only range
    always_ff @(posedge ref_clk) begin
        sel_q <= (req.addr == 6'h3F) ? fifo_data_in : status_in[req.addr[3:0]];
    end
    AST_RD_VALID: assert property (rd_ok |=> rvalid) else $error("no rvalid");
    AST_RO_READ: assert property (rd_ok && (req.addr <= 6'h0E) |=> rdata == sel_q) else $error("bad status");
    AST_FIFO_POP: assert property (rd_ok && req.addr == 6'h3F |=> fifo_pop && rdata == sel_q) else $error("pop");
    AST_TRIG_READ: assert property (rd_ok && req.addr == 6'h14 |=> rdata == 8'h00) else $error("trig read");
    AST_SOFT_PULSE: assert property (wr_ok && req.addr == 6'h14 && req.wdata == 8'hB6 |=> soft_reset_pulse)
        else $error("no soft reset");
    AST_INT_PULSE: assert property (wr_ok && req.addr == 6'h21 && req.wdata[7] |=> int_reset_pulse)
        else $error("no int reset");
    AST_SOFT_CLEARS: assert property (soft_reset_pulse |=> !rvalid && ctrl_out[32] == 8'h00) else $error("no clear");
    AST_WR_TAKE: assert property (wr_ok && req.addr == 6'h20 |=> ctrl_out[32] == ($past(req.wdata) & ~RESV_MASK_DEFAULT))
        else $error("write lost");
endmodule
bind grs_regs grs_regs_sva #(.RESV_MASK_DEFAULT(RESV_MASK_DEFAULT)) u_sva (.*);

// ===== tb/grs_host.sv
// Host model issuing single-byte register transfers.
// Assumes one caller at a time, on ref_clk.
`timescale 1ns/10ps
module grs_host (
    input wire logic ref_clk, // Clock
    output grs_pkg::grs_req_t req, // Request
    input wire logic [7:0] rdata, // Read byte
    input wire logic rvalid // Read valid
);
    initial req = '0;
    // Idle cycle between calls; a read without rvalid gives x
    // Fully reserved addresses are written like the others, then read back to check they read zero
    task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge ref_clk);
        #1 req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge ref_clk);
        #1 req = '0;
        q = rvalid ? rdata : 8'hXX;
    endtask
endmodule

// ===== tb/grs_regs_bench.sv
// Bench for the register bank access rules.
// Assumes grs_regs, grs_host and the checker compiled first.
`timescale 1ns/10ps
module grs_regs_bench;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    grs_pkg::grs_req_t req;
    logic [7:0] rdata, fifo_data_in, q, v;
    logic [7:0] status_in [0:14];
    logic [7:0] ctrl_out [0:63];
    logic rvalid, fifo_pop, soft_reset_pulse, int_reset_pulse;
    int fails = 0;
    int checked = 0;
    always #5 ref_clk = ~ref_clk;
    // 0x30 fully reserved, bit 6 reserved elsewhere
    grs_regs #(.RESERVED_MAP(64'h0001_0000_0000_0000), .RESV_MASK_DEFAULT(8'h40)) uut (.*);
    grs_host host (.ref_clk, .req, .rdata, .rvalid);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("Checks %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        fifo_data_in = 8'hC3;
        for (int i = 0; i < 15; i++) status_in[i] = 8'(8'h10 + i);
        repeat (12) @(posedge ref_clk);
        #1 nrst = 1'b1;
        for (int a = 0; a < 15; a++) begin
            host.xfer(1'b1, 6'(a), 8'hFF, q);
            host.xfer(1'b0, 6'(a), 8'h00, q);
            chk(q, 8'(8'h10 + a));
        end
        for (int a = 15; a < 64; a++) host.xfer(1'b1, 6'(a), 8'(a * 7 + 17), q);
        for (int a = 15; a < 64; a++) begin
            v = (a == 8'h14 || a == 8'h30) ? 8'h00 : 8'(a * 7 + 17) & (a == 8'h21 ? 8'h3F : 8'hBF);
            host.xfer(1'b0, 6'(a), 8'h00, q);
            chk(q, (a == 63) ? 8'hC3 : v);
        end
        chk({7'h00, fifo_pop}, 8'h01);
        host.xfer(1'b1, 6'h21, 8'hFF, q);
        chk({7'h00, int_reset_pulse}, 8'h01);
        host.xfer(1'b1, 6'h14, 8'hB6, q);
        chk({7'h00, soft_reset_pulse}, 8'h01);
        host.xfer(1'b0, 6'h20, 8'h00, q);
        chk(q, 8'h00);
        conclude();
    end
    initial begin
        #30000;
        fails++;
        conclude();
    end
endmodule
